/* pmc_pkg.sv */
// power mode controller constants and types
package pmc_pkg;
   // requested mode codes from the configuration routine
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_SLEEP  = 2'h1;
   localparam logic [1:0] MODE_DSLEEP = 2'h2;
   localparam logic [1:0] MODE_DPD    = 2'h3;
   // oscillator settle time and reset hold, ns
   localparam int OSC_SETTLE_NS  = 2000;
   localparam int RESET_HOLD_NS  = 1000;
   localparam int CLK_PERIOD_NS  = 25;
   localparam int OSC_SETTLE_CYC =
      (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_HOLD_CYC =
      (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // wake source bit positions in the deep-sleep mask
   localparam int WK_PIN   = 0;
   localparam int WK_GROUP = 1;
   localparam int WK_USB   = 2;
   localparam int WK_MIC   = 3;
   localparam int WK_SPI   = 4;
   localparam int WK_I2C   = 5;
   localparam int WK_USART = 6;
   localparam int WK_WDOG  = 7;
   localparam int WK_RTC   = 8;
   localparam int WK_UTICK = 9;
   localparam int WK_BROWN = 10;
   localparam int WK_DMA   = 11;
   localparam int WK_NUM   = 12;
   // analog keep-alive bit positions
   localparam int AN_FRO   = 0;
   localparam int AN_RTCO  = 1;
   localparam int AN_WDO   = 2;
   localparam int AN_BROWN = 3;
   localparam int AN_NUM   = 4;
   // controller states
   typedef enum logic [2:0] {
      ST_ACTIVE, ST_SLEEP, ST_DSLEEP, ST_WAKE_OSC, ST_DPD, ST_RESET
   } pmc_state_e;
endpackage

/* power_mode_controller.sv */
// power mode controller: sleep, deep-sleep and deep power-down
`timescale 1ns/100ps
module power_mode_controller #(
   parameter int NPERIPH    = 8,                         // gated peripherals
   parameter int SETTLE_CYC = pmc_pkg::OSC_SETTLE_CYC,   // main osc settle
   parameter int RESET_CYC  = pmc_pkg::RESET_HOLD_CYC    // reset sequence
) (
   input  wire logic                       clk,            // 40 MHz clock
   input  wire logic                       rst,            // sync reset
   input  wire logic [1:0]                 mode_req,       // requested mode
   input  wire logic                       mode_go,        // routine strobe
   input  wire logic [NPERIPH-1:0]         periph_clk_en,  // active clk gates
   input  wire logic [NPERIPH-1:0]         periph_pwr_en,  // active power
   input  wire logic [pmc_pkg::WK_NUM-1:0] deep_sleep_wake_enable_0, // mask
   input  wire logic [pmc_pkg::AN_NUM-1:0] analog_keep,    // analog keepalive
   input  wire logic                       usart_sync_slave, // usart mode
   input  wire logic                       usart_32k_mode, // usart 32k mode
   input  wire logic                       spi_slave,      // spi as slave
   input  wire logic                       i2c_slave,      // i2c as slave
   input  wire logic                       dma_ds_allowed, // dma in dsleep
   input  wire logic                       irq_pending,    // enabled irq
   input  wire logic [pmc_pkg::WK_NUM-1:0] wake_src,       // raw wake pins
   input  wire logic                       hw_activity_wake, // serial act.
   input  wire logic                       rtc_second_alarm_flag, // rtc
   input  wire logic                       reset_pin_n,    // reset pin
   output logic                            cpu_clk_en,     // core clock gate
   output logic                            main_clk_en,    // main clock on
   output logic                            fro_en,         // oscillator on
   output logic                            flash_standby,  // flash standby
   output logic                            flash_pwr,      // flash powered
   output logic [NPERIPH-1:0]              periph_clk_on,  // periph clocks
   output logic [NPERIPH-1:0]              periph_pwr_on,  // periph power
   output logic [pmc_pkg::AN_NUM-1:0]      analog_pwr,     // analog powered
   output logic                            dma_en,         // dma clock
   output logic                            retain,         // state retained
   output logic                            pin_hold,       // pins static
   output logic                            pin_tristate,   // pins floated
   output logic                            core_pwr,       // core domain on
   output logic                            chip_reset,     // reset sequence
   output logic                            rtc_wake_irq,   // rtc wake request
   output logic [1:0]                      mode_now        // current mode
);
   // synchronisers for pin-level inputs
   logic [pmc_pkg::WK_NUM-1:0] wk_s1_reg, wk_s2_reg;  // wake sources
   logic [2:0] misc_s1_reg, misc_s2_reg;  // hw wake, alarm, reset pin
   always_ff @(posedge clk) begin
      if (rst) begin
         wk_s1_reg   <= '0;
         wk_s2_reg   <= '0;
         misc_s1_reg <= 3'h4;
         misc_s2_reg <= 3'h4;
      end else begin
         wk_s1_reg   <= wake_src;
         wk_s2_reg   <= wk_s1_reg;
         misc_s1_reg <= {reset_pin_n, rtc_second_alarm_flag,
                         hw_activity_wake};
         misc_s2_reg <= misc_s1_reg;
      end
   end

   // decoded wake conditions
   wire hw_wake   = misc_s2_reg[0];
   wire alarm     = misc_s2_reg[1];
   wire pin_rst   = ~misc_s2_reg[2];
   // serial blocks wake only in their unclocked-capable modes
   wire usart_ok  = usart_sync_slave | usart_32k_mode;
   // wake mask with a single bit set at pos when v is high
   function automatic logic [pmc_pkg::WK_NUM-1:0] mask_bit(
      input int   pos,  // bit position in the wake mask
      input logic v     // value placed at that position
   );
      mask_bit = {{(pmc_pkg::WK_NUM-1){1'b0}}, v} << pos;
   endfunction

   // sources that cannot wake while unclocked are masked off
   wire [pmc_pkg::WK_NUM-1:0] src_ok;     // sources allowed to wake
   wire [pmc_pkg::WK_NUM-1:0] src_block;  // sources barred from waking
   assign src_block = mask_bit(pmc_pkg::WK_USART, ~usart_ok)
                    | mask_bit(pmc_pkg::WK_SPI, ~spi_slave)
                    | mask_bit(pmc_pkg::WK_I2C, ~i2c_slave)
                    | mask_bit(pmc_pkg::WK_DMA, ~dma_ds_allowed);
   assign src_ok = wk_s2_reg & ~src_block;
   wire ds_wake   = |(src_ok & deep_sleep_wake_enable_0)
                  | hw_wake | alarm;
   wire sl_wake   = irq_pending | hw_wake;
   wire dpd_wake  = pin_rst | alarm;

   // state and counter
   pmc_pkg::pmc_state_e state_reg, state_next;  // controller state
   logic [15:0]         cnt_reg, cnt_next;      // settle / reset count
   wire                 cnt_done;               // counter has run out
   wire [15:0]          cnt_dec;                // counter less one
   wire [15:0]          rst_load;               // reset sequence length
   wire [15:0]          osc_load;               // oscillator settle length

   // counter loads and decrement, parked at zero once done
   assign cnt_done = (cnt_reg == 16'h0000);
   assign cnt_dec  = cnt_done ? cnt_reg : cnt_reg - 16'h0001;
   assign rst_load = 16'(RESET_CYC);
   assign osc_load = 16'(SETTLE_CYC);

   // next-state logic; the reset pin beats every other wake
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_dec;
      case (state_reg)
         // only the configuration routine strobe leaves active
         pmc_pkg::ST_ACTIVE: begin
            if (mode_go) begin
               case (mode_req)
                  pmc_pkg::MODE_SLEEP:  state_next = pmc_pkg::ST_SLEEP;
                  pmc_pkg::MODE_DSLEEP: state_next = pmc_pkg::ST_DSLEEP;
                  pmc_pkg::MODE_DPD:    state_next = pmc_pkg::ST_DPD;
                  default:              state_next = pmc_pkg::ST_ACTIVE;
               endcase
            end
         end
         // core clock stopped until a reset or a wake
         pmc_pkg::ST_SLEEP: begin
            if (pin_rst) begin
               state_next = pmc_pkg::ST_RESET;
               cnt_next   = rst_load;
            end else if (sl_wake) begin
               state_next = pmc_pkg::ST_ACTIVE;
            end
         end
         // clocks stopped until a reset, an enabled wake source, hw activity or the alarm
         pmc_pkg::ST_DSLEEP: begin
            if (pin_rst) begin
               state_next = pmc_pkg::ST_RESET;
               cnt_next   = rst_load;
            end else if (ds_wake) begin
               state_next = pmc_pkg::ST_WAKE_OSC;
               cnt_next   = osc_load;
            end
         end
         // main clock running, core gate waits for it to settle
         pmc_pkg::ST_WAKE_OSC: begin
            if (cnt_done) begin
               state_next = pmc_pkg::ST_ACTIVE;
            end
         end
         // only the rtc domain and the reset pin are alive
         pmc_pkg::ST_DPD: begin
            if (dpd_wake) begin
               state_next = pmc_pkg::ST_RESET;
               cnt_next   = rst_load;
            end
         end
         // full reset sequence, stretched while the pin is low
         pmc_pkg::ST_RESET: begin
            if (cnt_done && !pin_rst) begin
               state_next = pmc_pkg::ST_ACTIVE;
            end
         end
         // an illegal code recovers through the reset sequence
         default: begin
            state_next = pmc_pkg::ST_RESET;
            cnt_next   = rst_load;
         end
      endcase
   end

   // state register, reset enters the reset sequence
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= pmc_pkg::ST_RESET;
         cnt_reg   <= 16'(RESET_CYC);
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // output decode for the next state, so outputs track it
   wire n_act  = (state_next == pmc_pkg::ST_ACTIVE);    // core running
   wire n_sl   = (state_next == pmc_pkg::ST_SLEEP);     // sleep
   wire n_ds   = (state_next == pmc_pkg::ST_DSLEEP);    // deep-sleep
   wire n_osc  = (state_next == pmc_pkg::ST_WAKE_OSC);  // clock settling
   wire n_dpd  = (state_next == pmc_pkg::ST_DPD);       // power-down
   wire n_rst  = (state_next == pmc_pkg::ST_RESET);     // reset sequence
   wire n_deep = n_ds | n_osc;  // deep-sleep or its wake
   wire n_run  = n_act | n_sl;  // peripheral clocks allowed

   // selected next values of the wider outputs
   wire [NPERIPH-1:0]         clk_on_next;  // peripheral clocks
   wire [NPERIPH-1:0]         pwr_on_next;  // peripheral power
   wire [pmc_pkg::AN_NUM-1:0] analog_next;  // analog power
   wire [pmc_pkg::AN_NUM-1:0] dpd_analog;   // rtc oscillator only
   wire [1:0]                 mode_next;    // reported mode
   wire                       fro_next;     // oscillator request

   assign clk_on_next = n_run ? periph_clk_en : '0;
   assign pwr_on_next = (n_run | n_deep) ? periph_pwr_en : '0;
   assign dpd_analog  = {{(pmc_pkg::AN_NUM-1){1'b0}}, 1'b1}
                        << pmc_pkg::AN_RTCO;
   assign analog_next = (n_run | n_rst) ? '1
                      : (n_deep ? analog_keep : dpd_analog);
   assign fro_next    = n_run | n_rst | n_osc
                      | (n_ds & analog_keep[pmc_pkg::AN_FRO]);
   assign mode_next   = n_sl ? pmc_pkg::MODE_SLEEP
                      : n_deep ? pmc_pkg::MODE_DSLEEP
                      : n_dpd ? pmc_pkg::MODE_DPD
                      : pmc_pkg::MODE_ACTIVE;

   // core clock gate opens only in active mode
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_clk_en <= 1'b0;
      end else begin
         cpu_clk_en <= n_act;
      end
   end

   // main clock off in deep-sleep and power-down, on while settling
   always_ff @(posedge clk) begin
      if (rst) begin
         main_clk_en <= 1'b1;
      end else begin
         main_clk_en <= ~n_ds & ~n_dpd;
      end
   end

   // free-running oscillator, kept in deep-sleep only on request
   always_ff @(posedge clk) begin
      if (rst) begin
         fro_en <= 1'b1;
      end else begin
         fro_en <= fro_next;
      end
   end

   // flash standby in deep-sleep, unpowered in power-down
   always_ff @(posedge clk) begin
      if (rst) begin
         flash_standby <= 1'b0;
         flash_pwr     <= 1'b1;
      end else begin
         flash_standby <= n_deep;
         flash_pwr     <= ~n_dpd;
      end
   end

   // peripheral clocks follow software gates while running
   always_ff @(posedge clk) begin
      if (rst) begin
         periph_clk_on <= '0;
      end else begin
         periph_clk_on <= clk_on_next;
      end
   end

   // peripheral power kept through sleep modes for retention
   always_ff @(posedge clk) begin
      if (rst) begin
         periph_pwr_on <= '0;
      end else begin
         periph_pwr_on <= pwr_on_next;
      end
   end

   // analog blocks, only the kept ones in deep-sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         analog_pwr <= '1;
      end else begin
         analog_pwr <= analog_next;
      end
   end

   // dma clock, limited use allowed in deep-sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         dma_en <= 1'b0;
      end else begin
         dma_en <= n_run | (n_deep & dma_ds_allowed);
      end
   end

   // state retention and static pins in sleep and deep-sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         retain   <= 1'b0;
         pin_hold <= 1'b0;
      end else begin
         retain   <= n_sl | n_deep;
         pin_hold <= n_sl | n_deep;
      end
   end

   // power-down floats the pins and removes core power
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_tristate <= 1'b0;
         core_pwr     <= 1'b1;
      end else begin
         pin_tristate <= n_dpd;
         core_pwr     <= ~n_dpd;
      end
   end

   // chip reset held through the reset sequence
   always_ff @(posedge clk) begin
      if (rst) begin
         chip_reset <= 1'b1;
      end else begin
         chip_reset <= n_rst;
      end
   end

   // rtc wake request follows the synced alarm flag
   always_ff @(posedge clk) begin
      if (rst) begin
         rtc_wake_irq <= 1'b0;
      end else begin
         rtc_wake_irq <= alarm;
      end
   end

   // reported mode code
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_now <= pmc_pkg::MODE_ACTIVE;
      end else begin
         mode_now <= mode_next;
      end
   end
endmodule

/* pmc_partner.sv */
// core and wake source model facing the power mode controller
`timescale 1ns/100ps
module pmc_partner (
   input  wire logic       clk, go, cpu_clk_en, // clock, call, core on
   input  wire logic [1:0] req,                 // mode asked for
   input  wire logic [2:0] kind,                // wake source to raise
   output logic [1:0]      mode_req,            // mode code out
   output logic            mode_go, irq_pending, // strobe, enabled irq
   output logic [pmc_pkg::WK_NUM-1:0] wake_src, // raw wake lines
   output logic            hw_activity_wake,    // serial activity
   output logic            rtc_second_alarm_flag, reset_pin_n // rtc, pin
);
   // quiet sources at power-up
   initial begin
      {mode_req, mode_go, irq_pending, wake_src} = 16'h0000;
      {hw_activity_wake, rtc_second_alarm_flag, reset_pin_n} = 3'h1;
   end
   // change lines just after the rising edge, held as levels
   always @(posedge clk) begin
      mode_req <= req;
      mode_go <= go && cpu_clk_en;
      irq_pending <= kind == 3'h1;
      hw_activity_wake <= kind == 3'h2;
      wake_src <= {11'h000, kind == 3'h3};
      rtc_second_alarm_flag <= kind == 3'h4;
      reset_pin_n <= kind != 3'h5;
   end
endmodule

/* pmc_checker.sv */
// port assertions for the power mode controller
`timescale 1ns/100ps
module pmc_checker #(parameter int NPERIPH = 8, SETTLE_CYC = 4) (
   input wire logic clk, rst, mode_go, cpu_clk_en, main_clk_en, // ctl
   input wire logic irq_pending, hw_activity_wake, reset_pin_n, // wakes
   input wire logic rtc_second_alarm_flag, flash_standby, retain, // state
   input wire logic pin_hold, pin_tristate, core_pwr, chip_reset, // power
   input wire logic [1:0] mode_req, mode_now,                   // modes
   input wire logic [NPERIPH-1:0] periph_clk_en, periph_clk_on, // gates
   input wire logic [pmc_pkg::AN_NUM-1:0] analog_keep, analog_pwr // analog
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] on_cnt;                                   // main clock run
   wire logic act = mode_now == pmc_pkg::MODE_ACTIVE && cpu_clk_en;
   wire logic take = act && mode_go;                     // request taken
   // count how long the main clock has been running
   always_ff @(posedge clk)
      on_cnt <= (rst || !main_clk_en) ? 8'h00
                : on_cnt + {7'h00, on_cnt != 8'hFF};
   AST_ACTIVE_GATES: assert property (act ##1 act |->
      periph_clk_on == $past(periph_clk_en)) else $error("gates");
   AST_SLEEP_ENTRY: assert property (take && mode_req == pmc_pkg::MODE_SLEEP
      |=> !cpu_clk_en && retain && pin_hold
      && mode_now == pmc_pkg::MODE_SLEEP) else $error("sleep entry");
   AST_DSLEEP_ENTRY: assert property (take && mode_req == pmc_pkg::MODE_DSLEEP
      |=> !cpu_clk_en && !main_clk_en && flash_standby
      && !(|periph_clk_on)) else $error("deep-sleep entry");
   AST_DSLEEP_ANALOG: assert property (mode_now == pmc_pkg::MODE_DSLEEP &&
      !main_clk_en |-> !(|(analog_pwr & ~analog_keep)))
      else $error("analog");
   AST_SLEEP_WAKE: assert property (mode_now == pmc_pkg::MODE_SLEEP
      && irq_pending |=> act) else $error("irq wake");
   AST_HW_WAKE: assert property ((mode_now == pmc_pkg::MODE_SLEEP &&
      hw_activity_wake)[*3] |-> ##[0:3] act) else $error("hw wake");
   AST_DPD_POWER: assert property (mode_now == pmc_pkg::MODE_DPD &&
      !chip_reset |-> !core_pwr && pin_tristate && !retain && !cpu_clk_en)
      else $error("dpd power");
   AST_DPD_HOLD: assert property ((mode_now == pmc_pkg::MODE_DPD &&
      reset_pin_n && !rtc_second_alarm_flag)[*3]
      |=> mode_now == pmc_pkg::MODE_DPD) else $error("dpd left");
   AST_DPD_EXIT: assert property ($past(mode_now) == pmc_pkg::MODE_DPD
      && mode_now != pmc_pkg::MODE_DPD |-> chip_reset) else $error("exit");
   AST_SETTLE: assert property ($rose(cpu_clk_en) |->
      on_cnt >= SETTLE_CYC) else $error("clock not settled");
   COV_SLEEP: cover property (take ##1 mode_now == pmc_pkg::MODE_SLEEP);
   COV_DSLEEP: cover property (mode_now == pmc_pkg::MODE_DSLEEP ##1 act);
   COV_DPD_EXIT: cover property (mode_now == pmc_pkg::MODE_DPD ##1 chip_reset);
endmodule

bind power_mode_controller pmc_checker #(.NPERIPH(NPERIPH),
   .SETTLE_CYC(SETTLE_CYC)) pmc_checker_i (.clk, .rst, .mode_go, .cpu_clk_en,
   .main_clk_en, .irq_pending, .hw_activity_wake, .reset_pin_n,
   .rtc_second_alarm_flag, .flash_standby, .retain, .pin_hold, .pin_tristate,
   .core_pwr, .chip_reset, .mode_req, .mode_now, .periph_clk_en,
   .periph_clk_on, .analog_keep, .analog_pwr);

/* tb_top.sv */
// self-checking testbench for the power mode controller
`timescale 1ns/100ps
module tb_top;
   logic clk = 1'h0, rst = 1'h1, go = 1'h0;             // clock, reset, call
   logic [7:0] periph_clk_en = 8'h00, periph_pwr_en = 8'h00;  // gates
   logic [11:0] deep_sleep_wake_enable_0 = 12'h001;     // pin wake only
   logic [3:0] analog_keep = 4'h2;                      // keep rtc osc
   logic [1:0] req = 2'h0, mode_req, mode_now;          // mode codes
   logic [2:0] kind = 3'h0;                             // wake source
   logic [11:0] wake_src;
   logic [7:0] periph_clk_on, periph_pwr_on;
   logic [3:0] analog_pwr;
   logic mode_go, irq_pending, hw_activity_wake, rtc_second_alarm_flag;
   logic reset_pin_n, cpu_clk_en, main_clk_en, flash_standby, retain;
   logic pin_hold, pin_tristate, core_pwr, chip_reset, rtc_wake_irq;
   logic usart_32k_mode = 1'h0, dma_ds_allowed = 1'h1;  // wake qualifiers
   logic fro_en, flash_pwr, dma_en;                     // power outputs
   int n_errors = 0, comparisons = 0;
   always #12.5 clk = ~clk;
   power_mode_controller #(.SETTLE_CYC(4), .RESET_CYC(4))
   power_mode_controller_i (.clk, .rst, .mode_req, .mode_go, .periph_clk_en,
      .periph_pwr_en, .deep_sleep_wake_enable_0, .analog_keep,
      .usart_sync_slave(1'h1), .usart_32k_mode, .spi_slave(1'h1),
      .i2c_slave(1'h1), .dma_ds_allowed, .irq_pending, .wake_src,
      .hw_activity_wake, .rtc_second_alarm_flag, .reset_pin_n, .cpu_clk_en,
      .main_clk_en, .fro_en, .flash_standby, .flash_pwr, .periph_clk_on,
      .periph_pwr_on, .analog_pwr, .dma_en, .retain, .pin_hold,
      .pin_tristate, .core_pwr, .chip_reset, .rtc_wake_irq, .mode_now);
   pmc_partner pmc_partner_i (.clk, .go, .cpu_clk_en, .req, .kind, .mode_req,
      .mode_go, .irq_pending, .wake_src, .hw_activity_wake,
      .rtc_second_alarm_flag, .reset_pin_n);
   // compare and count
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task close_out;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // bounded wait for a level, sampled on the falling edge
   task automatic wait_lvl(ref logic s, input logic v);
      @(negedge clk);
      for (int i = 0; i < 400 && s !== v; i++)
         @(negedge clk);
      if (s !== v) begin
         n_errors++;
         close_out();
      end
   endtask
   // ask the core model for a mode and wait for the gate to close
   task enter(input logic [1:0] m);
      @(posedge clk);
      req <= m;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      wait_lvl(cpu_clk_en, 1'h0);
   endtask
   // raise one wake source
   task raise(input logic [2:0] k);
      @(posedge clk);
      kind <= k;
   endtask
   // per-peripheral gates follow software in active mode
   task t_active;
      @(posedge clk);
      periph_clk_en <= 8'hA5;
      periph_pwr_en <= 8'h3C;
      repeat (2) @(negedge clk);
      check(periph_clk_on, 8'hA5);
      check(periph_pwr_on, 8'h3C);
   endtask
   // sleep, stay asleep, then wake by irq or hardware activity
   task t_sleep(input logic [2:0] k);
      enter(pmc_pkg::MODE_SLEEP);
      check(mode_now, pmc_pkg::MODE_SLEEP);
      check({retain, pin_hold}, 2'h3);
      check(periph_clk_on, 8'hA5);
      check(dma_en, 1'h1);
      repeat (6) @(negedge clk);
      check(cpu_clk_en, 1'h0);
      raise(k);
      wait_lvl(cpu_clk_en, 1'h1);
      check(mode_now, pmc_pkg::MODE_ACTIVE);
      raise(3'h0);
   endtask
   // deep-sleep entry state and pin wake through the mask
   task t_dsleep;
      enter(pmc_pkg::MODE_DSLEEP);
      check({main_clk_en, flash_standby, retain}, 3'h3);
      check(periph_clk_on, 8'h00);
      check(analog_pwr, 4'h2);
      check({fro_en, dma_en}, 2'h1);
      raise(3'h3);
      wait_lvl(cpu_clk_en, 1'h1);
      check(main_clk_en, 1'h1);
      raise(3'h0);
   endtask
   // deep power-down ignores irqs, leaves by alarm or reset pin
   task t_dpd(input logic [2:0] k);
      enter(pmc_pkg::MODE_DPD);
      check({pin_tristate, core_pwr, retain}, 3'h4);
      check(flash_pwr, 1'h0);
      raise(3'h1);
      repeat (8) @(negedge clk);
      check(mode_now, pmc_pkg::MODE_DPD);
      raise(k);
      wait_lvl(chip_reset, 1'h1);
      @(negedge clk);
      check(rtc_wake_irq, k == 3'h4);
      raise(3'h0);
      wait_lvl(cpu_clk_en, 1'h1);
      check({mode_now, chip_reset}, 3'h0);
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      wait_lvl(cpu_clk_en, 1'h1);
      t_active();
      t_sleep(3'h1);
      t_sleep(3'h2);
      t_dsleep();
      t_dpd(3'h4);
      t_dpd(3'h5);
      close_out();
   end
endmodule
